// ===== core/adc_output_format_control.sv
// converter output formatting stage with its serial configuration port and
// an 8-word output buffer.
// assumes samples arrive on mclk_i from the converter core and that the
// serial pins are asynchronous; sck must be slower than mclk_i / 4.
//
// Function
// - format register at address 04h, bits 7:6 ignored
// - pattern 000 passes normal conversion data
// - pattern 001 drives all outputs zero
// - pattern 011 drives all outputs one
// - pattern 101 alternates checkerboard per sample
// - pattern 111 alternates all zeros, all ones
// - bit 2 enables alternate bit polarity
// - bit 1 enables output scrambler
// - serial word: rw, 7 address, 8 data
// - only first 16 sck rising edges sampled
// - read leaves register, returns it on serial_out
// - software reset clears format register to 00h
`timescale 1ns/1ns
`default_nettype none

module sample_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             ready_r;
   wire              push_w = in_valid_i && in_ready_o;
   wire              pop_w  = out_valid_o && out_ready_i;
   wire [AW:0]       count_nxt = count_r + (AW+1)'(push_w) - (AW+1)'(pop_w);

   // ready is a flop of its own so the top's ready pin has no logic after it
   assign in_ready_o  = ready_r;
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];

   always_ff @(posedge mclk_i) begin
      if (ce_i && push_w) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         ready_r  <= 1'b1;
      end else if (ce_i) begin
         if (push_w) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop_w) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
         ready_r <= (count_nxt != (AW+1)'(DEPTH));
      end
   end
endmodule

module adc_output_format_control #(
   parameter int FIFO_DEPTH = fmt_pkg::FIFO_DEPTH
) (
   input  wire logic                          mclk_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          ce_i,
   // converter core side
   input  wire logic                          sample_valid_i,
   output logic                               sample_ready_o,
   input  wire logic [fmt_pkg::SAMPLE_W-1:0]  sample_bits_i,
   input  wire logic                          overrange_flag_i,
   // receiving logic side
   output logic                               out_valid_o,
   input  wire logic                          out_ready_i,
   output logic [fmt_pkg::SAMPLE_W-1:0]       sample_bits_o,
   output logic                               overrange_flag_o,
   // serial configuration pins
   input  wire logic                          cs_n_i,
   input  wire logic                          sck_i,
   input  wire logic                          serial_in_i,
   output logic                               serial_out_o,
   output logic                               serial_out_oe_o,
   // format register, visible for the rest of the chip
   output logic [7:0]                         data_format_control_o
);
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_HEADER = 4'b0010,
      ST_DATA   = 4'b0100,
      ST_DONE   = 4'b1000
   } port_state_t;

   // pin synchronisers; stage one is read only by stage two
   logic [2:0]          sync1_r;
   logic [2:0]          sync2_r;
   logic                sck_prev_r;
   port_state_t         state_r;
   port_state_t         state_nxt;
   logic [4:0]          edge_cnt_r;
   logic [15:0]         shift_r;
   logic [7:0]          read_back_r;
   logic                serial_out_low_r;
   logic                rd_cmd_r;
   logic [7:0]          format_r;
   logic                phase_r;
   logic                out_valid_r;
   fmt_pkg::sample_word_t out_word_r;

   wire cs_n_s   = sync2_r[2];
   wire sck_s    = sync2_r[1];
   wire serial_in_s = sync2_r[0];
   wire sck_rise = !cs_n_s && sck_s && !sck_prev_r;
   wire [15:0] word_w     = {shift_r[14:0], serial_in_s};
   wire        last_edge  = sck_rise && (edge_cnt_r == 5'(fmt_pkg::WORD_BITS - 1));
   wire        hdr_edge   = sck_rise && (edge_cnt_r == 5'(fmt_pkg::HDR_BITS - 1));
   wire        hdr_read   = word_w[7];
   wire [6:0]  hdr_addr   = word_w[6:0];
   wire        wr_format  = last_edge && !word_w[15] && (word_w[14:8] == fmt_pkg::ADDR_FORMAT);
   wire        wr_reset   = last_edge && !word_w[15] && (word_w[14:8] == fmt_pkg::ADDR_SW_RESET)
                            && word_w[fmt_pkg::SW_RESET_BIT];

   // serial port sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:   state_nxt = cs_n_s ? ST_IDLE : ST_HEADER;
         ST_HEADER: state_nxt = cs_n_s ? ST_IDLE : (hdr_edge ? ST_DATA : ST_HEADER);
         ST_DATA:   state_nxt = cs_n_s ? ST_IDLE : (last_edge ? ST_DONE : ST_DATA);
         ST_DONE:   state_nxt = cs_n_s ? ST_IDLE : ST_DONE;
         default:   state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         // idle pin levels: select high, clock low, so no false edge after reset
         sync1_r    <= 3'h4;
         sync2_r    <= 3'h4;
         sck_prev_r <= 1'b0;
      end else if (ce_i) begin
         sync1_r    <= {cs_n_i, sck_i, serial_in_i};
         sync2_r    <= sync1_r;
         sck_prev_r <= sync2_r[1];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_r    <= ST_IDLE;
         edge_cnt_r <= 5'h00;
         shift_r    <= 16'h0000;
      end else if (ce_i) begin
         state_r <= state_nxt;
         if (cs_n_s) begin
            edge_cnt_r <= 5'h00;
         end else if (sck_rise && (state_r != ST_DONE)) begin
            edge_cnt_r <= edge_cnt_r + 5'h01;
            shift_r    <= word_w;
         end
      end
   end

   // read back: after the header the addressed register shifts out msb first;
   // the pin only ever pulls low, the pull-up gives the ones
   wire [7:0] reg_view = (hdr_addr == fmt_pkg::ADDR_FORMAT) ? format_r : 8'h00;

   // the read flag is latched at the header: the shift register still holds
   // bits of the previous word above those shifted in so far
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         read_back_r      <= 8'h00;
         serial_out_low_r <= 1'b0;
         rd_cmd_r         <= 1'b0;
      end else if (ce_i) begin
         if (cs_n_s) begin
            serial_out_low_r <= 1'b0;
            rd_cmd_r         <= 1'b0;
         end else if (hdr_edge && hdr_read) begin
            read_back_r      <= {reg_view[6:0], 1'b0};
            serial_out_low_r <= !reg_view[7];
            rd_cmd_r         <= 1'b1;
         end else if (sck_rise && (state_r == ST_DATA) && rd_cmd_r && !last_edge) begin
            read_back_r      <= {read_back_r[6:0], 1'b0};
            serial_out_low_r <= !read_back_r[7];
         end else if (last_edge) begin
            serial_out_low_r <= 1'b0;
         end
      end
   end

   assign serial_out_o    = 1'b0;
   assign serial_out_oe_o = serial_out_low_r;

   // format register; reads never write it, software reset clears it
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         format_r <= fmt_pkg::FORMAT_RESET;
      end else if (ce_i) begin
         if (wr_reset) begin
            format_r <= fmt_pkg::FORMAT_RESET;
         end else if (wr_format) begin
            format_r <= word_w[7:0] & fmt_pkg::USED_MASK;
         end
      end
   end

   assign data_format_control_o = format_r;

   // sample formatting; settings are read per sample, so a new write
   // applies from the next accepted sample on
   fmt_pkg::format_cfg_t cfg_w;
   assign cfg_w = fmt_pkg::format_cfg_t'(format_r[5:0]);

   wire [fmt_pkg::SAMPLE_W-1:0] coded_w = cfg_w.signed_coding_select
        ? {~sample_bits_i[fmt_pkg::SAMPLE_W-1], sample_bits_i[fmt_pkg::SAMPLE_W-2:0]}
        : sample_bits_i;
   // scrambler: upper bits xored with the lsb, undone by the receiver
   wire [fmt_pkg::SAMPLE_W-1:0] scram_w = cfg_w.output_scrambler_enable
        ? {coded_w[fmt_pkg::SAMPLE_W-1:1] ^ {(fmt_pkg::SAMPLE_W-1){coded_w[0]}}, coded_w[0]}
        : coded_w;
   // alternate bit polarity: odd bits inverted on every other sample
   logic [fmt_pkg::SAMPLE_W-1:0] polarity_mask_w;
   for (genvar i = 0; i < fmt_pkg::SAMPLE_W; i++) begin : g_polarity
      assign polarity_mask_w[i] = (i % 2 == 1) && phase_r
                                  && cfg_w.alternate_bit_polarity_enable;
   end
   wire [14:0] normal_w  = {overrange_flag_i, scram_w ^ polarity_mask_w};
   wire [14:0] checker_w = phase_r ? ~fmt_pkg::CHECKER_A : fmt_pkg::CHECKER_A;
   wire [14:0] toggle_w  = {15{phase_r}};
   wire [2:0]  tp_w      = cfg_w.test_pattern_select;

   // unused codes fall through to normal data
   wire [14:0] pattern_w =
        (tp_w == fmt_pkg::TP_ZEROS)   ? 15'h0000  :
        (tp_w == fmt_pkg::TP_ONES)    ? 15'h7FFF  :
        (tp_w == fmt_pkg::TP_CHECKER) ? checker_w :
        (tp_w == fmt_pkg::TP_TOGGLE)  ? toggle_w  :
                                        normal_w;

   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [14:0] fifo_out_data;
   wire accept_w = sample_valid_i && fifo_in_ready;
   wire load_out = fifo_out_valid && (!out_valid_r || out_ready_i);

   assign sample_ready_o = fifo_in_ready;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         phase_r <= 1'b0;
      end else if (ce_i && accept_w) begin
         phase_r <= !phase_r;
      end
   end

   sample_fifo #(
      .WIDTH (15),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .in_valid_i  (sample_valid_i),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (pattern_w),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (load_out),
      .out_data_o  (fifo_out_data)
   );

   // output register so the pins come straight from flops
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         out_valid_r <= 1'b0;
         out_word_r  <= '0;
      end else if (ce_i) begin
         if (load_out) begin
            out_valid_r <= 1'b1;
            out_word_r  <= fmt_pkg::sample_word_t'(fifo_out_data);
         end else if (out_ready_i) begin
            out_valid_r <= 1'b0;
         end
      end
   end

   assign out_valid_o      = out_valid_r;
   assign sample_bits_o    = out_word_r.bits;
   assign overrange_flag_o = out_word_r.overrange;

endmodule

`default_nettype wire

// ===== core/fmt_pkg.sv
// package for the converter output formatting block: register map, field
// positions, reset values and the sample carrier type.
// assumes one conversion clock domain and a 14-bit sample path.
package fmt_pkg;

   localparam int          SAMPLE_W        = 14;
   localparam int          FIFO_DEPTH      = 8;
   localparam int          WORD_BITS       = 16;
   localparam int          HDR_BITS        = 8;

   // register addresses (7-bit serial address space)
   localparam logic [6:0]  ADDR_SW_RESET   = 7'h00;
   localparam logic [6:0]  ADDR_FORMAT     = 7'h04;

   // format register layout, software reset bit and value after reset
   localparam logic [7:0]  FORMAT_RESET    = 8'h00;
   localparam int          SW_RESET_BIT    = 7;
   localparam int          TP_MSB          = 5;
   localparam int          TP_LSB          = 3;
   localparam int          POLARITY_BIT    = 2;
   localparam int          SCRAMBLE_BIT    = 1;
   localparam int          SIGNED_BIT      = 0;
   localparam logic [7:0]  USED_MASK       = 8'h3F;

   // test pattern codes
   localparam logic [2:0]  TP_OFF          = 3'h0;
   localparam logic [2:0]  TP_ZEROS        = 3'h1;
   localparam logic [2:0]  TP_ONES         = 3'h3;
   localparam logic [2:0]  TP_CHECKER      = 3'h5;
   localparam logic [2:0]  TP_TOGGLE       = 3'h7;

   // checkerboard phase A for overrange plus sample bits: 101 0101 0101 0101
   localparam logic [14:0] CHECKER_A       = 15'h5555;

   typedef struct packed {
      logic                overrange;
      logic [SAMPLE_W-1:0] bits;
   } sample_word_t;

   typedef struct packed {
      logic [2:0] test_pattern_select;
      logic       alternate_bit_polarity_enable;
      logic       output_scrambler_enable;
      logic       signed_coding_select;
   } format_cfg_t;

endpackage

// ===== verification/adc_output_format_control_sva.sv
// checker for the output formatting block, sees its top ports only
// assumes one mclk_i domain and synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module fmt_sva #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic        ce_i,
   input wire logic        sample_valid_i,
   input wire logic        sample_ready_o,
   input wire logic        out_valid_o,
   input wire logic        out_ready_i,
   input wire logic [13:0] sample_bits_o,
   input wire logic        overrange_flag_o,
   input wire logic        cs_n_i,
   input wire logic        serial_out_oe_o,
   input wire logic [7:0]  data_format_control_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic [14:0] w  = {overrange_flag_o, sample_bits_o};
   wire logic [2:0]  tp = data_format_control_o[5:3];
   logic      [3:0]  seen_r;
   // words queued before a format change are gone after FIFO_DEPTH+1 handshakes
   wire logic        ok = out_valid_o && seen_r > 4'(FIFO_DEPTH + 1);
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || $changed(data_format_control_o))
         seen_r <= 4'h0;
      else if (ce_i && out_valid_o && out_ready_i && seen_r != 4'hF)
         seen_r <= seen_r + 4'h1;
   end
   property p_unused; data_format_control_o[7:6] == 2'h0; endproperty
   a_unused: assert property (p_unused) else $error("bits 7:6 set");
   property p_reset; $rose(rst_n_i) |-> data_format_control_o == 8'h00 && !out_valid_o; endproperty
   a_reset: assert property (p_reset) else $error("reset state");
   property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(w); endproperty
   a_hold: assert property (p_hold) else $error("word not held");
   property p_lat; sample_valid_i && sample_ready_o && ce_i |-> ##[1:3] out_valid_o; endproperty
   a_lat: assert property (p_lat) else $error("no output");
   property p_zero; ok && tp == 3'h1 |-> w == 15'h0000; endproperty
   a_zero: assert property (p_zero) else $error("zeros");
   property p_one; ok && tp == 3'h3 |-> w == 15'h7FFF; endproperty
   a_one: assert property (p_one) else $error("ones");
   property p_chk; ok && tp == 3'h5 |-> w == 15'h5555 || w == 15'h2AAA; endproperty
   a_chk: assert property (p_chk) else $error("checker");
   property p_alt; ok && tp == 3'h7 |-> w == 15'h0000 || w == 15'h7FFF; endproperty
   a_alt: assert property (p_alt) else $error("toggle");
   property p_serial_out; cs_n_i [*6] |-> !serial_out_oe_o; endproperty
   a_serial_out: assert property (p_serial_out) else $error("serial out driven");
endmodule
bind adc_output_format_control fmt_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva (.mclk_i, .rst_n_i,
   .ce_i, .sample_valid_i, .sample_ready_o, .out_valid_o, .out_ready_i, .sample_bits_o,
   .overrange_flag_o, .cs_n_i, .serial_out_oe_o, .data_format_control_o);
`default_nettype wire

// ===== verification/sample_receiver.sv
// receiving logic model: captures formatted words in order
// assumes words are consumed on valid and ready at the mclk_i rise
`timescale 1ns/1ns
`default_nettype none
module sample_receiver (
   input  wire logic        mclk_i,
   input  wire logic        stall_i,
   input  wire logic        valid_i,
   input  wire logic [14:0] word_i,
   output logic             ready_o
);
   logic [14:0] got [$];
   int          n = 0;
   initial ready_o = 1'b0;
   // stalling takes one word in three, slower than the source, so the buffer fills
   always @(negedge mclk_i) begin
      n = n + 1;
      ready_o = !stall_i || (n % 3 == 0);
   end
   always @(posedge mclk_i) begin
      if (valid_i && ready_o)
         got.push_back(word_i);
   end
endmodule
`default_nettype wire

// ===== verification/adc_output_format_control_tb.sv
// bench for the output formatting block: serial port tasks, sample streams
// assumes sample_receiver as the far side and the bound checker
`timescale 1ns/1ns
`default_nettype none
module adc_output_format_control_tb;
   logic        mclk_i = 1'b0, rst_n_i = 1'b0, sv = 1'b0, ovr = 1'b0;
   logic        cs_n = 1'b1, sck = 1'b0, serial_in = 1'b0, stall = 1'b0;
   logic        sr, ov, oo, so, oe, rdy;
   logic [13:0] sb = 14'h0000, ob;
   logic [7:0]  fmt, rd, cfg = 8'h00;
   logic [7:0]  tbl [10] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h00, 8'h10, 8'h30, 8'h01, 8'h02, 8'hE7};
   logic [14:0] exp_q [$];
   int          errors = 0, comparisons = 0, ph = 0;
   always #25 mclk_i = ~mclk_i;
   adc_output_format_control DUT (.mclk_i, .rst_n_i, .ce_i(1'b1), .sample_valid_i(sv),
      .sample_ready_o(sr), .sample_bits_i(sb), .overrange_flag_i(ovr), .out_valid_o(ov),
      .out_ready_i(rdy), .sample_bits_o(ob), .overrange_flag_o(oo), .cs_n_i(cs_n),
      .sck_i(sck), .serial_in_i(serial_in), .serial_out_o(so), .serial_out_oe_o(oe),
      .data_format_control_o(fmt));
   sample_receiver rx (.mclk_i, .stall_i(stall), .valid_i(ov), .word_i({oo, ob}), .ready_o(rdy));
   task automatic check(input logic [14:0] got, input logic [14:0] want);
      comparisons++;
      if (got !== want) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask
   function automatic logic [14:0] expect_w(logic [7:0] c, logic [14:0] s, int p);
      logic [13:0] b;
      b = s[13:0];
      case (c[5:3])
         3'h1: return 15'h0000;
         3'h3: return 15'h7FFF;
         3'h5: return p ? 15'h2AAA : 15'h5555;
         3'h7: return p ? 15'h7FFF : 15'h0000;
         default: begin
            if (c[0]) b[13] = ~b[13];
            if (c[1]) b[13:1] = b[13:1] ^ {13{b[0]}};
            if (c[2] && p) b = b ^ 14'h2AAA;
            return {s[14], b};
         end
      endcase
   endfunction
   // the pin reads high through its pull-up when released, else the driven level
   task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] d,
                      input int edges, output logic [7:0] r);
      logic [15:0] w;
      w = {rw, a, d};
      r = 8'h00;
      @(negedge mclk_i);
      cs_n = 1'b0;
      for (int i = 0; i < edges; i++) begin
         serial_in = (i < 16) ? w[15-i] : 1'b1;
         repeat (5) @(negedge mclk_i);
         if (i > 7 && i < 16) r[15-i] = oe ? so : 1'b1;
         sck = 1'b1;
         repeat (5) @(negedge mclk_i);
         sck = 1'b0;
      end
      cs_n = 1'b1;
      repeat (8) @(negedge mclk_i);
   endtask
   task automatic stream(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         @(negedge mclk_i);
         {ovr, sb} = 15'(i * 15'h1D37 + 15'h0A51);
         sv = 1'b1;
         k = 0;
         while (!sr && k < 100) begin
            @(negedge mclk_i);
            k++;
         end
         exp_q.push_back(expect_w(cfg, {ovr, sb}, ph));
         ph ^= 1;
      end
      @(negedge mclk_i);
      sv = 1'b0;
   endtask
   task automatic run_fmt(input logic [7:0] c);
      int k = 0;
      spi(1'b0, 7'h04, c, 16, rd);
      cfg = c & 8'h3F;
      spi(1'b1, 7'h04, 8'hFF, 16, rd);
      check({7'h00, rd}, {7'h00, cfg});
      check({7'h00, fmt}, {7'h00, cfg});
      stream(16);
      while (rx.got.size() < exp_q.size() && k < 600) begin
         @(negedge mclk_i);
         k++;
      end
      while (exp_q.size() > 0) check(rx.got.pop_front(), exp_q.pop_front());
      $display("test format %h done", c);
   endtask
   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge mclk_i);
      errors++;
      conclude();
   end
   initial begin
      repeat (12) @(negedge mclk_i);
      rst_n_i = 1'b1;
      // codes 010, 100 and 110 break the host's code on purpose
      foreach (tbl[i]) begin
         stall = i[0];
         run_fmt(tbl[i]);
      end
      spi(1'b0, 7'h04, 8'h2D, 18, rd);
      spi(1'b1, 7'h04, 8'h00, 16, rd);
      check({7'h00, rd}, 15'h002D);
      spi(1'b0, 7'h00, 8'h80, 16, rd);
      spi(1'b0, 7'h05, 8'hFF, 16, rd);
      spi(1'b1, 7'h04, 8'h00, 16, rd);
      check({7'h00, rd}, 15'h0000);
      spi(1'b1, 7'h03, 8'h00, 16, rd);
      check({7'h00, rd}, 15'h0000);
      $display("test serial done");
      conclude();
   end
endmodule
`default_nettype wire
